// >>> logic/uart_tx.sv
// Register access over APB and the address map are this design's own decisions.
`default_nettype none
module uart_tx
	import uart_tx_pkg::*;
(
	// system
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// receive side status
	input  wire logic        rx_unread,
	// pins
	input  wire logic        serial_clock_pin,
	input  wire logic        port_out,
	output var  logic        serial_out_pin,
	output var  logic        serial_out_oe_n,
	output var  logic        tx_busy
);
	////////////////////////////////////////////////////////////////
	logic rst_m_q, rst_s_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_s_q <= rst_m_q;
		end
	end
	logic xck_m_q, xck_s_q, xck_p_q, rxc_m_q, rxc_s_q;
	always_ff @(posedge clk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			xck_m_q <= 1'b0;
			xck_s_q <= 1'b0;
			xck_p_q <= 1'b0;
			rxc_m_q <= 1'b0;
			rxc_s_q <= 1'b0;
		end else begin
			xck_m_q <= serial_clock_pin;
			xck_s_q <= xck_m_q;
			xck_p_q <= xck_s_q;
			rxc_m_q <= rx_unread;
			rxc_s_q <= rxc_m_q;
		end
	end
	////////////////////////////////////////////////////////////////
	logic [7:0]  format_q;
	logic [11:0] divisor_q;
	logic        txen_q, u2x_q, csz2_q, tx_ninth_bit_q;
	logic        buf_full_q, txc_q;
	logic [7:0]  buf_q;
	logic        acc, wr, rd;
	assign acc = psel & penable;
	assign wr  = acc & pwrite;
	assign rd  = acc & ~pwrite;
	logic hit;
	assign hit = (paddr == status_off) || (paddr == control_off) || (paddr == format_off)
		|| (paddr == data_off) || (paddr == divisor_off);
	logic data_wr;
	assign data_wr = wr && (paddr == data_off);
	logic load, frame_end;
	always_ff @(posedge clk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			format_q  <= format_rst;
			divisor_q <= divisor_rst;
			txen_q    <= 1'b0;
			u2x_q     <= 1'b0;
			csz2_q    <= 1'b0;
			tx_ninth_bit_q    <= 1'b0;
		end else if (wr) begin
			if (paddr == format_off)
				format_q <= pwdata[7:0];
			if (paddr == divisor_off)
				divisor_q <= pwdata[11:0];
			if (paddr == status_off)
				u2x_q <= pwdata[st_u2x];
			if (paddr == control_off) begin
				txen_q <= pwdata[ct_txen];
				csz2_q <= pwdata[ct_csz2];
				tx_ninth_bit_q <= pwdata[ct_tx_ninth_bit];
			end
		end
	end
	always_ff @(posedge clk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			buf_q      <= 8'h00;
			buf_full_q <= 1'b0;
		end else if (data_wr) begin
			buf_q      <= pwdata[7:0];
			buf_full_q <= 1'b1;
		end else if (load)
			buf_full_q <= 1'b0;
	end
	always_ff @(posedge clk or negedge rst_s_q) begin
		if (!rst_s_q)
			txc_q <= 1'b0;
		else if (frame_end && !buf_full_q && !data_wr)
			txc_q <= 1'b1;
		else if (wr && paddr == status_off && pwdata[st_txc])
			txc_q <= 1'b0;
	end
	always_ff @(posedge clk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~pready;
			pslverr <= psel & ~pready & ~hit;
			prdata  <= 32'h0000_0000;
			if (psel && !pready && !pwrite) begin
				unique case (paddr)
					status_off: prdata <= {24'h0, rxc_s_q, txc_q, ~buf_full_q,
						3'h0, u2x_q, 1'b0};
					control_off: prdata <= {28'h0, txen_q, csz2_q, 1'b0, tx_ninth_bit_q};
					format_off: prdata <= {24'h0, format_q};
					divisor_off: prdata <= {20'h0, divisor_q};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////
	logic sync_mode;
	logic [2:0] csz;
	assign sync_mode = format_q[fm_sync];
	assign csz = {csz2_q, format_q[fm_csz1], format_q[fm_csz0]};
	logic [3:0] nbits;
	always_comb begin
		unique case (csz)
			3'h0: nbits = 4'd5;
			3'h1: nbits = 4'd6;
			3'h2: nbits = 4'd7;
			csz_nine: nbits = 4'd9;
			default: nbits = 4'd8;
		endcase
	end
	logic [11:0] baud_cnt_q;
	logic        baud_tick;
	logic        restart;
	assign baud_tick = (baud_cnt_q == 12'h000);
	// restart rate chain on idle load so the start bit is full length
	always_ff @(posedge clk or negedge rst_s_q) begin
		if (!rst_s_q)
			baud_cnt_q <= 12'h000;
		else if (baud_tick || restart || (wr && paddr == divisor_off))
			baud_cnt_q <= (wr && paddr == divisor_off) ? pwdata[11:0] : divisor_q;
		else
			baud_cnt_q <= baud_cnt_q - 12'h001;
	end
	logic [4:0] pre_q, pre_max;
	assign pre_max = sync_mode ? div_sync : (u2x_q ? div_double : div_normal);
	logic int_tick, ext_edge, bit_tick;
	assign int_tick = baud_tick && (pre_q == pre_max - 5'h01);
	always_ff @(posedge clk or negedge rst_s_q) begin
		if (!rst_s_q)
			pre_q <= 5'h00;
		else if (restart || int_tick || pre_q >= pre_max)
			pre_q <= 5'h00;
		else if (baud_tick)
			pre_q <= pre_q + 5'h01;
	end
	assign ext_edge = format_q[fm_pol] ? (xck_p_q & ~xck_s_q) : (~xck_p_q & xck_s_q);
	assign bit_tick = sync_mode ? ext_edge : int_tick;
	////////////////////////////////////////////////////////////////
	tx_state_e   state_q;
	logic [8:0]  sh_q;
	logic [3:0]  cnt_q;
	logic        par_q;
	logic        out_q;
	logic        pm_en;
	assign pm_en = format_q[fm_pm1];
	assign frame_end = bit_tick && ((state_q == st_stop1 && !format_q[fm_stop])
		|| state_q == st_stop2);
	assign load = buf_full_q && txen_q
		&& ((state_q == st_idle && (!sync_mode || bit_tick)) || frame_end);
	assign restart = load && (state_q == st_idle) && !sync_mode;
	logic [8:0] ld_word;
	always_comb begin
		ld_word = {tx_ninth_bit_q, buf_q};
		if (nbits < 4'd9)
			ld_word[8] = 1'b0;
		for (int i = 5; i < 8; i++)
			if (i >= int'(nbits))
				ld_word[i] = 1'b0;
	end
	always_ff @(posedge clk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			state_q <= st_idle;
			sh_q    <= 9'h000;
			cnt_q   <= 4'h0;
			par_q   <= 1'b0;
			out_q   <= 1'b1;
		end else if (load && txen_q) begin
			state_q <= st_start;
			sh_q    <= ld_word;
			par_q   <= (^ld_word) ^ format_q[fm_pm0];
			cnt_q   <= 4'h0;
			out_q   <= 1'b0;
		end else if (bit_tick) begin
			unique case (state_q)
				st_idle: out_q <= 1'b1;
				st_start, st_data: begin
					if (state_q == st_data && cnt_q == nbits) begin
						state_q <= pm_en ? st_parity : st_stop1;
						out_q   <= pm_en ? par_q : 1'b1;
					end else begin
						state_q <= st_data;
						out_q   <= sh_q[0];
						sh_q    <= {1'b0, sh_q[8:1]};
						cnt_q   <= cnt_q + 4'h1;
					end
				end
				st_parity: begin
					state_q <= st_stop1;
					out_q   <= 1'b1;
				end
				st_stop1: begin
					state_q <= format_q[fm_stop] ? st_stop2 : st_idle;
					out_q   <= 1'b1;
				end
				st_stop2: begin
					state_q <= st_idle;
					out_q   <= 1'b1;
				end
				default: state_q <= st_idle;
			endcase
		end
	end
	// pin hands over only once idle with the buffer empty after disable
	logic own_q;
	always_ff @(posedge clk or negedge rst_s_q) begin
		if (!rst_s_q) begin
			own_q           <= 1'b0;
			serial_out_pin  <= 1'b1;
			serial_out_oe_n <= 1'b1;
			tx_busy         <= 1'b0;
		end else begin
			own_q           <= txen_q | (state_q != st_idle) | buf_full_q;
			serial_out_pin  <= own_q ? out_q : port_out;
			serial_out_oe_n <= 1'b0;
			tx_busy         <= state_q != st_idle;
		end
	end
	////////////////////////////////////////////////////////////////
	chk_parity_value: assert property (@(posedge clk) disable iff (!rst_s_q)
		(load && txen_q) |=> par_q == ((^$past(ld_word)) ^ $past(format_q[fm_pm0])))
		else $error("parity bit wrong");
	chk_start_low: assert property (@(posedge clk) disable iff (!rst_s_q)
		(load && txen_q) |=> (state_q == st_start && !out_q))
		else $error("start bit not low");
	chk_idle_high: assert property (@(posedge clk) disable iff (!rst_s_q)
		(state_q == st_idle && bit_tick && !load) |=> out_q)
		else $error("idle line not high");
	chk_write_fills: assert property (@(posedge clk) disable iff (!rst_s_q)
		data_wr |=> buf_full_q)
		else $error("write did not fill buffer");
	chk_load_idle: assert property (@(posedge clk) disable iff (!rst_s_q)
		(buf_full_q && txen_q && state_q == st_idle && (!sync_mode || bit_tick) && !data_wr)
		|=> !buf_full_q)
		else $error("idle shifter not loaded");
	chk_txc_set: assert property (@(posedge clk) disable iff (!rst_s_q)
		(frame_end && !buf_full_q && !data_wr) |=> txc_q)
		else $error("complete flag not set");
	chk_parity_slot: assert property (@(posedge clk) disable iff (!rst_s_q)
		(state_q == st_parity) |-> out_q == par_q)
		else $error("parity slot wrong");
	chk_pin_owner: assert property (@(posedge clk) disable iff (!rst_s_q)
		own_q |=> serial_out_pin == $past(out_q))
		else $error("pin not driven by transmitter");
	chk_pready_pulse: assert property (@(posedge clk) disable iff (!rst_s_q)
		pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_slverr_pair: assert property (@(posedge clk) disable iff (!rst_s_q)
		pslverr |-> pready)
		else $error("error without ready");
	chk_busy_state: assert property (@(posedge clk) disable iff (!rst_s_q)
		1'b1 |=> tx_busy == $past(state_q != st_idle))
		else $error("busy flag wrong");
	chk_idle_disabled: assert property (@(posedge clk) disable iff (!rst_s_q)
		(state_q == st_idle && !txen_q) |=> state_q == st_idle)
		else $error("frame started while disabled");
	chk_buf_hold: assert property (@(posedge clk) disable iff (!rst_s_q)
		(buf_full_q && !txen_q) |=> buf_full_q)
		else $error("buffer lost while disabled");
	chk_stop_high: assert property (@(posedge clk) disable iff (!rst_s_q)
		(state_q == st_stop1 || state_q == st_stop2) |-> out_q)
		else $error("stop bit not high");
	chk_data_count: assert property (@(posedge clk) disable iff (!rst_s_q)
		(state_q == st_data) |-> cnt_q <= nbits)
		else $error("too many data bits");
	chk_ninth_cap: assert property (@(posedge clk) disable iff (!rst_s_q)
		(load && nbits == 4'd9) |=> sh_q[8] == $past(tx_ninth_bit_q))
		else $error("ninth bit not captured");
	chk_upper_mask: assert property (@(posedge clk) disable iff (!rst_s_q)
		(load && nbits < 4'd8) |=> sh_q[8:7] == 2'h0)
		else $error("upper bits not masked");
	chk_txc_hold: assert property (@(posedge clk) disable iff (!rst_s_q)
		(txc_q && !(wr && paddr == status_off && pwdata[st_txc])) |=> txc_q)
		else $error("complete flag dropped");
	chk_oe_driving: assert property (@(posedge clk) disable iff (!rst_s_q)
		1'b1 |=> !serial_out_oe_n)
		else $error("pin not driven");
	cov_frame: cover property (@(posedge clk) disable iff (!rst_s_q) frame_end);
	cov_b2b: cover property (@(posedge clk) disable iff (!rst_s_q) frame_end && load);
	cov_parity: cover property (@(posedge clk) disable iff (!rst_s_q) state_q == st_parity);
	cov_sync: cover property (@(posedge clk) disable iff (!rst_s_q) sync_mode && frame_end);
	cov_nine: cover property (@(posedge clk) disable iff (!rst_s_q) load && nbits == 4'd9);
endmodule
`default_nettype wire

// >>> logic/uart_tx_pkg.sv
`default_nettype none
package uart_tx_pkg;
	localparam logic [31:0] status_off  = 32'h0000_0000;
	localparam logic [31:0] control_off = 32'h0000_0004;
	localparam logic [31:0] format_off  = 32'h0000_0008;
	localparam logic [31:0] data_off    = 32'h0000_000c;
	localparam logic [31:0] divisor_off = 32'h0000_0010;
	// status fields
	localparam int st_rxc  = 7;
	localparam int st_txc  = 6;
	localparam int st_udre = 5;
	localparam int st_u2x  = 1;
	// control fields
	localparam int ct_txen = 3;
	localparam int ct_csz2 = 2;
	localparam int ct_tx_ninth_bit = 0;
	// format fields
	localparam int fm_sync = 6;
	localparam int fm_pm1  = 5;
	localparam int fm_pm0  = 4;
	localparam int fm_stop = 3;
	localparam int fm_csz1 = 2;
	localparam int fm_csz0 = 1;
	localparam int fm_pol  = 0;
	localparam logic [7:0]  format_rst  = 8'h06;
	localparam logic [11:0] divisor_rst = 12'h000;
	localparam logic [4:0]  div_normal  = 5'h10;
	localparam logic [4:0]  div_double  = 5'h08;
	localparam logic [4:0]  div_sync    = 5'h02;
	localparam logic [2:0]  csz_nine    = 3'h7;
	typedef enum logic [2:0] {
		st_idle   = 3'b000,
		st_start  = 3'b001,
		st_data   = 3'b010,
		st_parity = 3'b011,
		st_stop1  = 3'b100,
		st_stop2  = 3'b101
	} tx_state_e;
endpackage
`default_nettype wire

// >>> verification/serial_rx_model.sv
`default_nettype none
module serial_rx_model #(
	parameter int bit_cyc = 8
) (
	// link
	input  wire logic       clk,
	input  wire logic       line,
	input  wire logic       armed,
	// frame shape
	input  wire logic [3:0] nbits,
	input  wire logic       par_en,
	input  wire logic       two_stop,
	// results
	output var  logic [8:0] data,
	output var  logic       par,
	output var  logic       stop_ok,
	output var  int         n_frames,
	output var  time        t_start
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		n_frames = 0;
		forever begin
			@(posedge clk iff (armed && line === 1'b0));
			t_start = $time;
			data    = '0;
			repeat (bit_cyc / 2) @(posedge clk);
			stop_ok = (line === 1'b0);
			for (int i = 0; i < nbits; i++) begin
				repeat (bit_cyc) @(posedge clk);
				data[i] = line;
			end
			if (par_en) begin
				repeat (bit_cyc) @(posedge clk);
				par = line;
			end
			for (int i = 0; i <= two_stop; i++) begin
				repeat (bit_cyc) @(posedge clk);
				stop_ok &= (line === 1'b1);
			end
			n_frames++;
		end
	end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin n_mismatch++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module tb_top
	import uart_tx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [8:0] d; logic [2:0] csz; logic pe, odd, st2;} row_s;
	logic        clk, rst_n, psel, penable, pwrite, rx_unread, port_out, armed;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic        pready, pslverr, pin, err, m_par, m_stop, par_en, two_stop;
	logic [3:0]  nbits;
	logic        xck_run, sync_sel;
	logic        xck = 1'b0;
	int          xck_n;
	logic [8:0]  m_data;
	int          n_frames, n_mismatch, n_compared, cyc, k;
	time         t_start, t0;
	row_s        rows [5] = '{'{9'h1a5, 3'h7, 1, 1, 0}, '{9'h0ff, 3'h0, 1, 0, 1},
		'{9'h03c, 3'h3, 1, 0, 0}, '{9'h080, 3'h2, 1, 1, 1}, '{9'h12d, 3'h1, 0, 0, 0}};
	uart_tx uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_unread(rx_unread), .serial_clock_pin(xck), .port_out(port_out),
		.serial_out_pin(pin), .serial_out_oe_n(), .tx_busy());
	serial_rx_model #(.bit_cyc(8)) rx (.clk(clk), .line(pin), .armed(armed), .nbits(nbits),
		.par_en(par_en), .two_stop(two_stop), .data(m_data), .par(m_par), .stop_ok(m_stop),
		.n_frames(n_frames), .t_start(t_start));
	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_frames(input int n);
		for (int i = 0; i < 3000 && n_frames < n; i++) @(posedge clk);
	endtask
	task automatic send(input row_s r);
		logic [8:0] m;
		nbits    = (r.csz == csz_nine) ? 4'd9 : 4'd5 + {2'b0, r.csz[1:0]};
		m        = (9'h1 << nbits) - 9'h1;
		par_en   = r.pe;
		two_stop = r.st2;
		apb(1, format_off, {25'h0, sync_sel, r.pe, r.odd, r.st2, r.csz[1:0], 1'b0});
		apb(1, control_off, {28'h0, 1'b1, r.csz[2], 1'b0, r.d[8]});
		apb(1, status_off, 32'h42);
		k = n_frames;
		apb(1, data_off, {23'h0, r.d});
		apb(1, control_off, {28'h0, 1'b1, r.csz[2], 1'b0, ~r.d[8]});
		wait_frames(k + 1);
		`CHK("data", r.d & m, m_data)
		if (r.pe) `CHK("parity", ^(r.d & m) ^ r.odd, m_par)
		`CHK("stop", 1'b1, m_stop)
		apb(0, status_off, 0);
		for (int i = 0; i < 20 && rd[st_txc] !== 1'b1; i++) apb(0, status_off, 0);
		`CHK("txc", 1'b1, rd[st_txc])
		`CHK("empty", 1'b1, rd[st_udre])
		$display("frame %h done", r.d);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (xck_run) begin
			xck_n++;
			if (xck_n % 4 == 0) xck <= ~xck;
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rx_unread, armed, rst_n} = '0;
		xck_run  = 1'b0;
		sync_sel = 1'b0;
		port_out = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		apb(0, format_off, 0);
		`CHK("format", format_rst, rd[7:0])
		rx_unread <= 1'b1;
		apb(0, status_off, 0);
		apb(0, status_off, 0);
		`CHK("rxc", 1'b1, rd[st_rxc])
		`CHK("empty", 1'b1, rd[st_udre])
		`CHK("port", 1'b0, pin)
		apb(0, 32'h14, 0);
		`CHK("slverr", 1'b1, err)
		`CHK("rdata", 32'h0, rd)
		apb(1, divisor_off, 0);
		apb(1, status_off, 32'h2);
		apb(1, control_off, 32'h8);
		repeat (3) @(posedge clk);
		`CHK("idle", 1'b1, pin)
		armed = 1'b1;
		$display("reset and setup done");
		foreach (rows[i]) send(rows[i]);
		send('{9'h0aa, 3'h3, 0, 0, 0});
		k = n_frames;
		apb(1, data_off, 32'h55);
		apb(1, data_off, 32'ha3);
		apb(0, status_off, 0);
		`CHK("full", 1'b0, rd[st_udre])
		wait_frames(k + 1);
		t0 = t_start;
		wait_frames(k + 2);
		`CHK("second", 9'h0a3, m_data)
		`CHK("gap", 64'd1600, t_start - t0)
		$display("back to back done");
		xck_run  = 1'b1;
		sync_sel = 1'b1;
		send('{9'h0c6, 3'h3, 1, 1, 0});
		$display("synchronous done");
		print_verdict();
	end
endmodule
`default_nettype wire
